// file: include/mii_port_pkg.sv
// constants for the external phy media independent interface port
package mii_port_pkg;
    // clocking and management clock limit
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned MDC_MAX_HZ    = 2_500_000;
    // half period rounded up so the clock never exceeds the limit
    localparam int unsigned MDC_HALF_CYC  = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
    localparam int unsigned MDC_HALF_MIN  = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);

    // management frame layout, bit index counted from first bit sent
    localparam int unsigned MG_FRAME_BITS = 64;
    localparam logic [5:0]  MG_LAST_BIT   = 6'h3F;
    localparam logic [5:0]  MG_TA_BIT     = 6'h2E;
    localparam logic [5:0]  MG_DATA_BIT   = 6'h30;
    localparam logic [31:0] MG_PREAMBLE   = 32'hFFFFFFFF;
    localparam logic [1:0]  MG_START      = 2'h1;
    localparam logic [1:0]  MG_OP_READ    = 2'h2;
    localparam logic [1:0]  MG_OP_WRITE   = 2'h1;
    localparam logic [1:0]  MG_TA_WRITE   = 2'h2;

    // boot rom address bits carried on the shared pins
    localparam int unsigned ROM_RXD_LSB   = 6;
    localparam int unsigned ROM_RXER_BIT  = 10;
    localparam int unsigned ROM_RXDV_BIT  = 11;
    localparam int unsigned ROM_TXD_LSB   = 12;
    localparam int unsigned ROM_ADDR_LSB  = 6;
    localparam int unsigned ROM_ADDR_W    = 10;

    // number of inputs passed through the synchroniser
    localparam int unsigned SYNC_W        = 11;

    typedef enum logic [0:0] {
        MG_IDLE  = 1'b0,
        MG_SHIFT = 1'b1
    } mg_state_e;
endpackage

// file: core/mii_sync.sv
// two flip-flop synchroniser for a vector of unrelated levels
`timescale 1ns/10ps
module mii_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst_n,
    // levels
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    initial begin
        if (W < 1) $error("mii_sync width must be at least one");
    end

    always_comb begin
        st_d      = st_q;
        st_d.meta = i_async;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_sync = st_q.sync;
endmodule

// file: core/mii_external_phy_port.sv
// mii port to an external phy, shared boot rom address pins and line mode select
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - management data clock is generated here at no more than 2.5 MHz
// - one shared management data line, each side drives only in its turn
// - receive output enable silences the phy during every boot rom access
// - during rom access rx data, rx error, rx valid and tx data pins output rom address bits 6 to 15
// - transmit nibbles leave synchronous to transmit clock, bit 3 most significant
// - transmit enable is high exactly while transmit nibble holds valid data
// - all interface outputs float unless external phy enable is set; tx, rx and receive output enable pins also drive during rom access
// - line driver and receiver mode follows forced setting or negotiation result
// - 10 Mb/s mode sends manchester data with normal and fast link pulses
// - 100 Mb/s mode accepts scrambled mlt-3 line data
module mii_external_phy_port #(
    parameter int unsigned MDC_HALF_CYC = mii_port_pkg::MDC_HALF_CYC
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // configuration
    input  wire logic        i_external_phy_enable,
    input  wire logic        i_force_speed,
    input  wire logic        i_force_100,
    input  wire logic        i_aneg_done,
    input  wire logic        i_aneg_100,
    // phy input pins
    input  wire logic        i_rx_clk,
    input  wire logic [3:0]  i_rxd,
    input  wire logic        i_rx_dv,
    input  wire logic        i_rx_er,
    input  wire logic        i_tx_clk,
    input  wire logic        i_crs,
    input  wire logic        i_col,
    // management pins
    output logic             o_mdc,
    output logic             o_mdc_oe,
    input  wire logic        i_mdio,
    output logic             o_mdio,
    output logic             o_mdio_oe,
    // transmit pins
    output logic [3:0]       o_txd,
    output logic             o_tx_en,
    output logic             o_tx_oe,
    // shared receive pins driven during rom access
    output logic [3:0]       o_rxd,
    output logic             o_rx_er,
    output logic             o_rx_dv,
    output logic             o_rx_pins_oe,
    output logic             o_rx_output_enable,
    output logic             o_rx_output_enable_oe,
    // boot rom address user side
    input  wire logic        i_rom_access,
    input  wire logic [9:0]  i_boot_rom_address,
    // transmit stream user side
    input  wire logic        i_tx_valid,
    input  wire logic [3:0]  i_tx_data,
    output logic             o_tx_ready,
    // receive stream user side
    output logic [3:0]       o_rx_data,
    output logic             o_rx_valid,
    output logic             o_rx_error,
    output logic             o_rx_frame,
    output logic             o_carrier,
    output logic             o_collision,
    // management user side
    input  wire logic        i_mg_start,
    input  wire logic        i_mg_write,
    input  wire logic [4:0]  i_mg_phy,
    input  wire logic [4:0]  i_mg_reg,
    input  wire logic [15:0] i_mg_wdata,
    output logic             o_mg_busy,
    output logic             o_mg_done,
    output logic [15:0]      o_mg_rdata,
    // internal transceiver mode
    output logic             o_line_mode_100
);
    localparam int unsigned DIVW = $clog2(MDC_HALF_CYC + 1);
    localparam logic [DIVW-1:0] DIV_LAST = DIVW'(MDC_HALF_CYC - 1);

    initial begin
        if (MDC_HALF_CYC < mii_port_pkg::MDC_HALF_MIN)
            $error("management clock half period too short for the rate limit");
    end

    typedef struct packed {
        mii_port_pkg::mg_state_e mg;
        logic [5:0]      idx;
        logic [63:0]     sh;
        logic [15:0]     rdata;
        logic            rd_op;
        logic [DIVW-1:0] div;
        logic            mdc;
        logic            mdc_oe;
        logic            mdio;
        logic            mdio_oe;
        logic            done;
        logic            rxc_prev;
        logic            txc_prev;
        logic [3:0]      rx_data;
        logic            rx_valid;
        logic            rx_err;
        logic            rx_frame;
        logic [3:0]      txd;
        logic            tx_en;
        logic            tx_oe;
        logic [9:0]      rom;
        logic            rom_oe;
        logic            rx_output_enable;
        logic            rx_output_enable_oe;
        logic            mode100;
    } port_s;

    port_s st_q;
    port_s st_d;

    logic [mii_port_pkg::SYNC_W-1:0] sy;
    logic       rxc_s;
    logic       txc_s;
    logic [3:0] rxd_s;
    logic       rxdv_s;
    logic       rxer_s;
    logic       mdio_s;
    logic       rx_fall;
    logic       tx_fall;
    logic       tx_take;
    logic       div_wrap;

    ////////////////////////////////////////////////////////////////////////////
    // every pin from the phy is sampled twice before use
    mii_sync #(
        .W (mii_port_pkg::SYNC_W)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async ({i_rx_clk, i_tx_clk, i_rxd, i_rx_dv, i_rx_er, i_mdio, i_crs, i_col}),
        .o_sync  (sy)
    );

    assign {rxc_s, txc_s, rxd_s, rxdv_s, rxer_s, mdio_s, o_carrier, o_collision} = sy;

    // data is taken mid-cycle, on the falling edge, where the phy holds it stable
    assign rx_fall  = st_q.rxc_prev & ~rxc_s;
    assign tx_fall  = st_q.txc_prev & ~txc_s;
    // pins are rom address while an access runs, so the stream stalls
    assign tx_take  = tx_fall & i_external_phy_enable & ~i_rom_access;
    assign div_wrap = (st_q.div == DIV_LAST);
    assign o_tx_ready = tx_take;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d          = st_q;
        st_d.done     = 1'b0;
        st_d.rx_valid = 1'b0;
        st_d.rxc_prev = rxc_s;
        st_d.txc_prev = txc_s;

        // receive path
        if (rx_fall && i_external_phy_enable && !i_rom_access) begin
            st_d.rx_frame = rxdv_s;
            st_d.rx_valid = rxdv_s;
            st_d.rx_err   = rxdv_s & rxer_s;
            if (rxdv_s) begin
                st_d.rx_data = rxd_s;
            end
        end else if (i_rom_access || !i_external_phy_enable) begin
            st_d.rx_frame = 1'b0;
            st_d.rx_err   = 1'b0;
        end

        // transmit path
        if (tx_take) begin
            st_d.tx_en = i_tx_valid;
            st_d.txd   = i_tx_valid ? i_tx_data : 4'h0;
        end else if (i_rom_access || !i_external_phy_enable) begin
            st_d.tx_en = 1'b0;
        end

        // shared pins
        st_d.rom     = i_boot_rom_address;
        st_d.rom_oe  = i_rom_access;
        st_d.rx_output_enable    = i_external_phy_enable & ~i_rom_access;
        st_d.rx_output_enable_oe = i_external_phy_enable | i_rom_access;
        st_d.tx_oe   = i_external_phy_enable | i_rom_access;
        st_d.mdc_oe  = i_external_phy_enable;

        // management engine
        unique case (st_q.mg)
            mii_port_pkg::MG_IDLE: begin
                st_d.mdc     = 1'b0;
                st_d.div     = '0;
                st_d.mdio_oe = 1'b0;
                if (i_mg_start && i_external_phy_enable) begin
                    st_d.mg    = mii_port_pkg::MG_SHIFT;
                    st_d.idx   = 6'h00;
                    st_d.rd_op = ~i_mg_write;
                    st_d.sh    = {mii_port_pkg::MG_PREAMBLE, mii_port_pkg::MG_START,
                                  i_mg_write ? mii_port_pkg::MG_OP_WRITE
                                             : mii_port_pkg::MG_OP_READ,
                                  i_mg_phy, i_mg_reg, mii_port_pkg::MG_TA_WRITE,
                                  i_mg_write ? i_mg_wdata : 16'h0000};
                    st_d.mdio    = 1'b1;
                    st_d.mdio_oe = 1'b1;
                end
            end
            mii_port_pkg::MG_SHIFT: begin
                st_d.div = div_wrap ? '0 : st_q.div + 1'b1;
                if (div_wrap) begin
                    st_d.mdc = ~st_q.mdc;
                    if (!st_q.mdc) begin
                        // rising edge: phy data is sampled here
                        if (st_q.rd_op && st_q.idx >= mii_port_pkg::MG_DATA_BIT) begin
                            st_d.rdata = {st_q.rdata[14:0], mdio_s};
                        end
                    end else if (st_q.idx == mii_port_pkg::MG_LAST_BIT) begin
                        st_d.mg      = mii_port_pkg::MG_IDLE;
                        st_d.done    = 1'b1;
                        st_d.mdio_oe = 1'b0;
                    end else begin
                        // falling edge: next bit goes out
                        st_d.idx     = st_q.idx + 6'h01;
                        st_d.sh      = {st_q.sh[62:0], 1'b0};
                        st_d.mdio    = st_q.sh[62];
                        // release the line from turnaround on for reads
                        st_d.mdio_oe = ~st_q.rd_op
                                     | (st_q.idx + 6'h01 < mii_port_pkg::MG_TA_BIT);
                    end
                end
            end
        endcase

        // internal transceiver mode select
        if (i_force_speed) begin
            st_d.mode100 = i_force_100;
        end else if (i_aneg_done) begin
            st_d.mode100 = i_aneg_100;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            st_q    <= '0;
            st_q.mg <= mii_port_pkg::MG_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    localparam int unsigned RA = mii_port_pkg::ROM_ADDR_LSB;

    assign o_mdc      = st_q.mdc;
    assign o_mdc_oe   = st_q.mdc_oe;
    assign o_mdio     = st_q.mdio;
    assign o_mdio_oe  = st_q.mdio_oe & st_q.mdc_oe;
    // rom address wins the transmit pins; tx_en is held low meanwhile
    assign o_txd      = st_q.rom_oe ? st_q.rom[mii_port_pkg::ROM_TXD_LSB-RA +: 4] : st_q.txd;
    assign o_tx_en    = st_q.tx_en;
    assign o_tx_oe    = st_q.tx_oe;
    assign o_rxd      = st_q.rom[mii_port_pkg::ROM_RXD_LSB-RA +: 4];
    assign o_rx_er    = st_q.rom[mii_port_pkg::ROM_RXER_BIT-RA];
    assign o_rx_dv    = st_q.rom[mii_port_pkg::ROM_RXDV_BIT-RA];
    assign o_rx_pins_oe          = st_q.rom_oe;
    assign o_rx_output_enable    = st_q.rx_output_enable;
    assign o_rx_output_enable_oe = st_q.rx_output_enable_oe;
    assign o_rx_data  = st_q.rx_data;
    assign o_rx_valid = st_q.rx_valid;
    assign o_rx_error = st_q.rx_err;
    assign o_rx_frame = st_q.rx_frame;
    assign o_mg_busy  = (st_q.mg == mii_port_pkg::MG_SHIFT);
    assign o_mg_done  = st_q.done;
    assign o_mg_rdata = st_q.rdata;
    // low: manchester with normal and fast link pulses; high: scrambled mlt-3
    assign o_line_mode_100 = st_q.mode100;
endmodule

// file: test/mii_port_checker_assertions.sv
// assertions on the external phy port pins and user side
`timescale 1ns/10ps
module mii_port_checker (
    // clock and reset
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    // user inputs and phy levels
    input wire logic       i_external_phy_enable,
    input wire logic       i_rom_access,
    input wire logic [9:0] i_boot_rom_address,
    input wire logic       i_tx_valid,
    input wire logic [3:0] i_tx_data,
    input wire logic       i_crs,
    input wire logic       i_col,
    // outputs under watch
    input wire logic       o_tx_ready,
    input wire logic       o_tx_en,
    input wire logic [3:0] o_txd,
    input wire logic       o_tx_oe,
    input wire logic [3:0] o_rxd,
    input wire logic       o_rx_er,
    input wire logic       o_rx_dv,
    input wire logic       o_rx_pins_oe,
    input wire logic       o_rx_output_enable,
    input wire logic       o_rx_output_enable_oe,
    input wire logic       o_mdc,
    input wire logic       o_mdc_oe,
    input wire logic       o_mg_busy,
    input wire logic       o_rx_valid,
    input wire logic       o_rx_frame,
    input wire logic       o_carrier,
    input wire logic       o_collision
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
////////////////////////////////////////////////////////////////////////////////
    mdc_high_a: assert property ($rose(o_mdc) |-> ##19 o_mdc ##1 !o_mdc)
        else $error("management clock high phase wrong");
    mdc_idle_a: assert property (!o_mg_busy && !$past(o_mg_busy) |-> !o_mdc)
        else $error("management clock runs while idle");
    rx_output_enable_rom_a: assert property ($past(i_rom_access) |->
        !o_rx_output_enable && o_rx_output_enable_oe) else $error("phy not silenced");
    rom_addr_a: assert property ($past(i_rom_access) |-> o_rx_pins_oe &&
        {o_txd, o_rx_dv, o_rx_er, o_rxd} == $past(i_boot_rom_address))
        else $error("rom address pins wrong");
    float_off_a: assert property (!$past(i_external_phy_enable) &&
        !$past(i_rom_access) |-> !o_tx_oe && !o_rx_output_enable_oe && !o_mdc_oe)
        else $error("pins driven while disabled");
    tx_take_a: assert property (o_tx_ready && i_tx_valid |=>
        o_tx_en && o_txd == $past(i_tx_data)) else $error("nibble not sent");
    tx_end_a: assert property (o_tx_ready && !i_tx_valid |=> !o_tx_en)
        else $error("transmit enable outlives data");
    sync_in_a: assert property ({o_carrier, o_collision} == $past({i_crs, i_col}, 2))
        else $error("carrier or collision lag wrong");
    rx_pulse_a: assert property (o_rx_valid |-> o_rx_frame ##1 !o_rx_valid)
        else $error("receive valid not a pulse in frame");
endmodule
bind mii_external_phy_port mii_port_checker chk (.*);

// file: test/mii_phy_model.sv
// behavioural external phy: clocks, receive frames, collision, mdio replies
`timescale 1ns/10ps
module mii_phy_model #(
    parameter logic [15:0] MG_VALUE = 16'hC3A5
) (
    // management side
    input  wire logic       i_mdc,
    input  wire logic       i_mdio,
    // transmit side
    input  wire logic [3:0] i_txd,
    input  wire logic       i_tx_en,
    // pins driven by the phy
    output logic            o_rx_clk,
    output logic            o_tx_clk,
    output logic [3:0]      o_rxd,
    output logic            o_rx_dv,
    output logic            o_rx_er,
    output logic            o_crs,
    output logic            o_col,
    output logic            o_mdio,
    output logic            o_mdio_oe
);
    logic [3:0]  got[$];
    logic [1:0]  op = 2'h0;
    int unsigned bit_n = 0;
    logic [31:0] frame_got = 32'h00000000;
    initial begin
        {o_rxd, o_rx_dv, o_rx_er, o_crs, o_col, o_mdio, o_mdio_oe} = 10'h000;
        o_rx_clk = 1'b0;
        o_tx_clk = 1'b0;
    end
    // clocks run free, phases kept off the rising system clock edges
    always #80 o_rx_clk = ~o_rx_clk;
    initial begin
        #2.7;
        forever #80 o_tx_clk = ~o_tx_clk;
    end
    always @(posedge o_tx_clk) if (i_tx_en) got.push_back(i_txd);
    task automatic send_frame(input int n);
        o_crs = 1'b1;
        for (int k = 0; k <= n; k++) begin
            @(posedge o_rx_clk);
            o_rx_dv = (k < n);
            o_rxd   = (k < n) ? 4'(k * 3 + 1) : ~o_rxd;
            o_rx_er = (k == 2);
        end
        o_crs = 1'b0;
    endtask
    task automatic collide(input int ns);
        o_col = 1'b1;
        #(ns);
        o_col = 1'b0;
    endtask
    // frames are always whole, so the bit count simply wraps at 64
    always @(posedge i_mdc) begin
        // line as seen from start delimiter to last data bit, before any turn change
        if (bit_n >= 32) frame_got = {frame_got[30:0], i_mdio};
        if (bit_n == 34 || bit_n == 35) op = {op[0], i_mdio};
        o_mdio_oe = (op == 2'h2 && bit_n >= 46 && bit_n < 63);
        o_mdio    = (bit_n >= 47 && bit_n <= 62) ? MG_VALUE[62 - bit_n] : 1'b0;
        bit_n     = (bit_n + 1) % 64;
    end
endmodule

// file: test/mii_external_phy_port_tb_top.sv
// self checking bench for the external phy port
`timescale 1ns/10ps
module mii_external_phy_port_tb_top;
    localparam logic [15:0] MG_VALUE = 16'hC3A5;
    logic        i_clock = 1'b0, i_rst_n = 1'b0, i_external_phy_enable = 1'b0;
    logic        i_force_speed = 1'b0, i_force_100 = 1'b0, i_aneg_done = 1'b0;
    logic        i_aneg_100 = 1'b0, i_rom_access = 1'b0, i_tx_valid = 1'b0;
    logic        i_mg_start = 1'b0, i_mg_write = 1'b0;
    logic [3:0]  i_tx_data = 4'h0;
    logic [9:0]  i_boot_rom_address = 10'h000;
    logic [4:0]  i_mg_phy = 5'h01, i_mg_reg = 5'h02;
    logic [15:0] i_mg_wdata = 16'h5AA5;
    logic        i_rx_clk, i_tx_clk, i_rx_dv, i_rx_er, i_crs, i_col, i_mdio, p_mdio;
    logic        p_mdio_oe, o_mdc, o_mdc_oe, o_mdio, o_mdio_oe, o_tx_en, o_tx_oe, o_rx_er;
    logic        o_rx_dv, o_rx_pins_oe, o_rx_output_enable, o_rx_output_enable_oe;
    logic        o_tx_ready, o_rx_valid, o_rx_error, o_rx_frame, o_carrier, o_collision;
    logic        o_mg_busy, o_mg_done, o_line_mode_100;
    logic [3:0]  i_rxd, o_txd, o_rxd, o_rx_data;
    logic [15:0] o_mg_rdata;
    int          n_fail = 0, checks_done = 0;
    always #5 i_clock = ~i_clock;
    // pulled-up line, so a released line reads high
    assign i_mdio = o_mdio_oe ? o_mdio : (p_mdio_oe ? p_mdio : 1'b1);
    mii_external_phy_port dut (.*);
    mii_phy_model #(.MG_VALUE(MG_VALUE)) phy (.i_mdc(o_mdc), .i_mdio(i_mdio), .i_txd(o_txd),
        .i_tx_en(o_tx_en), .o_rx_clk(i_rx_clk), .o_tx_clk(i_tx_clk), .o_rxd(i_rxd),
        .o_rx_dv(i_rx_dv), .o_rx_er(i_rx_er), .o_crs(i_crs), .o_col(i_col),
        .o_mdio(p_mdio), .o_mdio_oe(p_mdio_oe));
////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (exp !== got) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    // returns on the edge where the signal is sampled high; call it just off an edge,
    // so the level is read settled and not in the time step that launches it
    task automatic wait_hi(ref logic s, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            if (s === 1'b1) break;
            tick(1);
        end
        if (k == lim) begin
            check("wait", 16'h0001, {15'h0000, s});
            conclude();
        end
        @(posedge i_clock);
    endtask
////////////////////////////////////////////////////////////////////////////////
    task automatic t_idle();
        check("enables", 16'h0000,
              {12'h000, o_tx_oe, o_rx_output_enable_oe, o_mdc_oe, o_rx_pins_oe});
        i_external_phy_enable = 1'b1;
        tick(2);
        check("enables", 16'h000F,
              {12'h000, o_tx_oe, o_rx_output_enable_oe, o_mdc_oe, o_rx_output_enable});
        $display("idle test done");
    endtask
    task automatic t_mode();
        // fourth row holds the earlier 100 Mb/s result while negotiation is not done
        logic [4:0] md[5] = '{5'h19, 5'h16, 5'h07, 5'h03, 5'h04};
        foreach (md[k]) begin
            {i_force_speed, i_force_100, i_aneg_done, i_aneg_100} = md[k][4:1];
            tick(2);
            check("mode", {15'h0000, md[k][0]}, {15'h0000, o_line_mode_100});
        end
        $display("mode test done");
    endtask
    task automatic t_rom();
        logic [9:0] a[2] = '{10'h2A5, 10'h15A};
        foreach (a[k]) begin
            i_rom_access = 1'b1;
            i_boot_rom_address = a[k];
            tick(2);
            check("rom addr", {6'h00, a[k]},
                  {6'h00, o_txd, o_rx_dv, o_rx_er, o_rxd});
            check("rom oe", 16'h0006,
                  {13'h0000, o_rx_pins_oe, o_rx_output_enable_oe, o_rx_output_enable});
        end
        i_rom_access = 1'b0;
        tick(2);
        check("rx_output_enable", 16'h0001, {14'h0000, o_rx_pins_oe, o_rx_output_enable});
        $display("rom test done");
    endtask
    task automatic t_tx();
        for (int k = 0; k <= 5; k++) begin
            i_tx_valid = (k < 5);
            i_tx_data  = 4'(k * 5 + 2);
            wait_hi(o_tx_ready, 100);
            #1;
        end
        tick(40);
        check("tx count", 16'h0005, 16'(phy.got.size()));
        foreach (phy.got[k]) check("txd", {12'h000, 4'(k * 5 + 2)},
                                   {12'h000, phy.got[k]});
        $display("tx test done");
    endtask
    task automatic t_rx();
        fork
            phy.send_frame(6);
        join_none
        for (int k = 0; k < 6; k++) begin
            wait_hi(o_rx_valid, 100);
            #1;
            check("rxd", {12'h000, 4'(k * 3 + 1)}, {12'h000, o_rx_data});
            check("rx err", {15'h0000, k == 2}, {15'h0000, o_rx_error});
        end
        check("carrier", 16'h0001, {15'h0000, o_carrier});
        tick(40);
        check("frame", 16'h0000, {15'h0000, o_rx_frame});
        $display("rx test done");
    endtask
    task automatic t_col();
        fork
            phy.collide(95);
        join_none
        tick(4);
        check("collision", 16'h0001, {15'h0000, o_collision});
        tick(12);
        check("collision", 16'h0000, {15'h0000, o_collision});
        $display("collision test done");
    endtask
    task automatic t_mg(input logic wr);
        i_mg_write = wr;
        i_mg_start = 1'b1;
        tick(1);
        i_mg_start = 1'b0;
        check("mg busy", 16'h0001, {15'h0000, o_mg_busy});
        wait_hi(o_mg_done, 2700);
        #1;
        check("mg idle", 16'h0000, {15'h0000, o_mg_busy});
        // start, op, addresses and turnaround as the phy saw them on the line
        check("mg head", {2'h1, wr ? 2'h1 : 2'h2, i_mg_phy, i_mg_reg, 2'h2},
              phy.frame_got[31:16]);
        check("mg data", wr ? i_mg_wdata : MG_VALUE, phy.frame_got[15:0]);
        if (!wr) check("mg read", MG_VALUE, o_mg_rdata);
        $display("management test done");
    endtask
    initial begin
        tick(16);
        i_rst_n = 1'b1;
        tick(2);
        t_idle();
        t_mode();
        t_rom();
        t_tx();
        t_rx();
        t_col();
        t_mg(1'b1);
        t_mg(1'b0);
        conclude();
    end
endmodule
